/* File: rsc_pkg.sv */
// Package of constants for the receive start-symbol and clock recovery block
package rsc_pkg;
   // Clock rate of the block's own clock
   localparam int CLK_MHZ = 250;
   // Internal pulse source, in kHz, and stage on-time in ns
   localparam int PULSE_SRC_KHZ = 614;
   localparam int STAGE_ON_NS = 814;
   // Cycles per half of the pulse period, rounded down (longest time)
   localparam int STAGE_ON_CYC = (STAGE_ON_NS * CLK_MHZ) / 1000;
   // Dead time between stages so enables never overlap
   localparam int DEAD_CYC = 1;
   // Start pattern, sent most significant bit first
   localparam logic [15:0] START_PATTERN = 16'hE2E2;
   localparam int START_LEN = 16;
   // Default oversampling: block clocks per data bit
   localparam int BIT_CYC_DEF = 64;
   // Gain settings in dB, for reference by the gain select output
   localparam int GAIN_HIGH_DB = 35;
   localparam int GAIN_LOW_DB = 5;
   // Reset values
   localparam logic GAIN_SEL_RST = 1'b1;
endpackage

/* File: rsc_amp_seq.sv */
// Amplifier stage sequencer with guaranteed non-overlapping enables
`timescale 1ns/1ps
`default_nettype none
module rsc_amp_seq #(
   parameter int ON_CYC = rsc_pkg::STAGE_ON_CYC,
   parameter int GAP_CYC = rsc_pkg::DEAD_CYC
) (
   input wire logic clk, // Block clock
   input wire logic resetn, // Synchronous reset, active low
   output logic amp1_en_q, // First stage enable
   output logic amp2_en_q // Second stage enable
);
   typedef enum logic [1:0] {RSC_S1, RSC_G1, RSC_S2, RSC_G2} rsc_seq_t;
   rsc_seq_t st_q;
   logic [15:0] cnt_q;
   // Refuse timings that leave no on time or no gap between the stages
   if (ON_CYC < 2 || ON_CYC > 65535 ||
       GAP_CYC < 1 || GAP_CYC >= ON_CYC) begin : g_bad_timing
      $error("rsc_amp_seq: bad timing parameters");
   end
   // On time is shortened by the gap so the full period stays on the source
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_q <= RSC_S1;
         cnt_q <= 16'h0000;
      end else if (st_q == RSC_S1 || st_q == RSC_S2) begin
         if (cnt_q == 16'(ON_CYC - GAP_CYC - 1)) begin
            cnt_q <= 16'h0000;
            st_q <= (st_q == RSC_S1) ? RSC_G1 : RSC_G2;
         end else begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end else begin
         if (cnt_q == 16'(GAP_CYC - 1)) begin
            cnt_q <= 16'h0000;
            st_q <= (st_q == RSC_G1) ? RSC_S2 : RSC_S1;
         end else begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end
   end
   // Enables registered from state; gap states drive both low
   always_ff @(posedge clk) begin
      if (!resetn) begin
         amp1_en_q <= 1'b0;
         amp2_en_q <= 1'b0;
      end else begin
         amp1_en_q <= (st_q == RSC_S1);
         amp2_en_q <= (st_q == RSC_S2);
      end
   end
   property p_no_overlap;
      @(posedge clk) disable iff (!resetn) !(amp1_en_q && amp2_en_q);
   endproperty
   a_no_overlap: assert property (p_no_overlap)
      else $error("both amplifier stages enabled");
   property p_gap_after1;
      @(posedge clk) disable iff (!resetn)
         $fell(amp1_en_q) |-> !amp2_en_q;
   endproperty
   a_gap_after1: assert property (p_gap_after1)
      else $error("second stage rose with first stage fall");
   property p_alternate;
      @(posedge clk) disable iff (!resetn)
         $fell(amp1_en_q) |-> ##[1:4] amp2_en_q;
   endproperty
   a_alternate: assert property (p_alternate)
      else $error("second stage did not follow first");
endmodule
`default_nettype wire

/* File: rsc_top.sv */
// Receive digital control: amp sequencing, gain, slicing, clock recovery
`timescale 1ns/1ps
`default_nettype none
module rsc_top #(
   parameter int BIT_CYC = rsc_pkg::BIT_CYC_DEF
) (
   input wire logic clk, // Block clock, 250 MHz
   input wire logic resetn, // Synchronous reset, active low
   input wire logic saturation_onset_flag, // From first stage, async
   input wire logic threshold_slicer, // Slicer decision, async
   input wire logic peak_relative_slicer, // Slicer decision, async
   input wire logic recovery_enable_bit, // Host enable, async
   output logic first_rf_amp_stage, // First stage bias enable
   output logic second_rf_amp_stage, // Second stage bias enable
   output logic gain_sel_high_q, // 1 = 35 dB, 0 = 5 dB
   output logic rx_data_pin, // Receive data out
   output logic recovered_clock_pin // Recovered bit clock out
);
   typedef enum logic [1:0] {RSC_IDLE, RSC_HUNT, RSC_RUN} rsc_st_t;
   rsc_st_t st_q;
   logic [1:0] sat_s_q, ts_s_q, ps_s_q, en_s_q;
   logic comp_q, comp_prev_q;
   logic [15:0] phase_q;
   logic [15:0] shift_q;
   logic [4:0] fill_q;
   logic centre;
   logic [16:0] since_rise_q;
   // Refuse bit lengths that leave no room between centre and bit end
   if (BIT_CYC < 4 || BIT_CYC > 65535) begin : g_bad_bit_cyc
      $error("rsc_top: BIT_CYC out of range");
   end
   // Last count of a bit period; shared by the phase wrap and clock fall
   function automatic logic at_bit_end(input logic [15:0] ph);
      return ph == 16'(BIT_CYC - 1);
   endfunction
   // Stage sequencer in its own module
   rsc_amp_seq rsc_amp_seq_inst (
      .clk(clk),
      .resetn(resetn),
      .amp1_en_q(first_rf_amp_stage),
      .amp2_en_q(second_rf_amp_stage)
   );
   // Two-flop synchronisers for every async pin input
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sat_s_q <= 2'b00;
         ts_s_q <= 2'b00;
         ps_s_q <= 2'b00;
         en_s_q <= 2'b00;
      end else begin
         sat_s_q <= {sat_s_q[0], saturation_onset_flag};
         ts_s_q <= {ts_s_q[0], threshold_slicer};
         ps_s_q <= {ps_s_q[0], peak_relative_slicer};
         en_s_q <= {en_s_q[0], recovery_enable_bit};
      end
   end
   // Gain select follows the saturation flag; no hysteresis is modelled
   always_ff @(posedge clk) begin
      if (!resetn) begin
         gain_sel_high_q <= rsc_pkg::GAIN_SEL_RST;
      end else begin
         gain_sel_high_q <= !sat_s_q[1];
      end
   end
   // Compound decision from both slicers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         comp_q <= 1'b0;
         comp_prev_q <= 1'b0;
      end else begin
         comp_q <= ts_s_q[1] & ps_s_q[1];
         comp_prev_q <= comp_q;
      end
   end
   // Bit phase counter resyncs on every data edge; centre is half a bit on
   assign centre = (phase_q == 16'(BIT_CYC / 2));
   always_ff @(posedge clk) begin
      if (!resetn) begin
         phase_q <= 16'h0000;
      end else if (comp_q != comp_prev_q) begin
         phase_q <= 16'h0000;
      end else if (at_bit_end(phase_q)) begin
         phase_q <= 16'h0000;
      end else begin
         phase_q <= phase_q + 16'h0001;
      end
   end
   // Pattern shifter sampled at bit centres, newest bit in the LSB
   always_ff @(posedge clk) begin
      if (!resetn || st_q != RSC_HUNT) begin
         shift_q <= 16'h0000;
         fill_q <= 5'h00;
      end else if (centre) begin
         shift_q <= {shift_q[14:0], comp_q};
         if (fill_q != 5'(rsc_pkg::START_LEN))
            fill_q <= fill_q + 5'h01;
      end
   end
   // Recovery state: a cleared enable ends a run; rearm needs enable again
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_q <= RSC_IDLE;
      end else begin
         case (st_q)
            RSC_IDLE: if (en_s_q[1]) st_q <= RSC_HUNT;
            RSC_HUNT: begin
               if (!en_s_q[1])
                  st_q <= RSC_IDLE;
               else if (fill_q == 5'(rsc_pkg::START_LEN) &&
                        shift_q == rsc_pkg::START_PATTERN)
                  st_q <= RSC_RUN;
            end
            RSC_RUN: if (!en_s_q[1]) st_q <= RSC_IDLE;
            default: st_q <= RSC_IDLE;
         endcase
      end
   end
   // Pin outputs: raw decision until start, then retimed data with clock
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rx_data_pin <= 1'b0;
         recovered_clock_pin <= 1'b0;
      end else if (st_q != RSC_RUN) begin
         rx_data_pin <= comp_q;
         recovered_clock_pin <= 1'b0;
      end else if (centre) begin
         rx_data_pin <= comp_q;
         recovered_clock_pin <= 1'b1;
      end else if (at_bit_end(phase_q)) begin
         recovered_clock_pin <= 1'b0;
      end
   end
   // Low time of the recovered clock in a run; a stall shows up here
   always_ff @(posedge clk) begin
      if (!resetn || st_q != RSC_RUN || recovered_clock_pin) begin
         since_rise_q <= 17'h0_0000;
      end else if (since_rise_q != 17'h1_ffff) begin
         since_rise_q <= since_rise_q + 17'h0_0001;
      end
   end
   property p_keep_pulsing;
      @(posedge clk) disable iff (!resetn)
         since_rise_q < 17'(2 * BIT_CYC);
   endproperty
   a_keep_pulsing: assert property (p_keep_pulsing)
      else $error("recovered clock stopped during a run");
   property p_clk_falls;
      @(posedge clk) disable iff (!resetn)
         (st_q == RSC_RUN && at_bit_end(phase_q)) |=> !recovered_clock_pin;
   endproperty
   a_clk_falls: assert property (p_clk_falls)
      else $error("recovered clock did not fall before the next bit");
   property p_clk_low_idle;
      @(posedge clk) disable iff (!resetn)
         (st_q != RSC_RUN) |=> !recovered_clock_pin;
   endproperty
   a_clk_low_idle: assert property (p_clk_low_idle)
      else $error("recovered clock pulsed outside a run");
   property p_clk_off;
      @(posedge clk) disable iff (!resetn)
         (!en_s_q[1]) |=> ##1 !recovered_clock_pin;
   endproperty
   a_clk_off: assert property (p_clk_off)
      else $error("recovered clock active while disabled");
   property p_passthru;
      @(posedge clk) disable iff (!resetn)
         (st_q != RSC_RUN) |=> (rx_data_pin == $past(comp_q));
   endproperty
   a_passthru: assert property (p_passthru)
      else $error("data pin not following the slicer");
   property p_and;
      @(posedge clk) disable iff (!resetn)
         comp_q |-> $past(ts_s_q[1]) && $past(ps_s_q[1]);
   endproperty
   a_and: assert property (p_and)
      else $error("compound decision not the slicer AND");
   property p_gain;
      @(posedge clk) disable iff (!resetn)
         sat_s_q[1] |=> !gain_sel_high_q;
   endproperty
   a_gain: assert property (p_gain)
      else $error("low gain not chosen on saturation");
   property p_start;
      @(posedge clk) disable iff (!resetn)
         (st_q == RSC_HUNT && en_s_q[1] &&
          fill_q == 5'(rsc_pkg::START_LEN) &&
          shift_q == rsc_pkg::START_PATTERN) |=> (st_q == RSC_RUN);
   endproperty
   a_start: assert property (p_start)
      else $error("start pattern missed");
   property p_rise_at_centre;
      @(posedge clk) disable iff (!resetn)
         $rose(recovered_clock_pin) |-> $past(centre);
   endproperty
   a_rise_at_centre: assert property (p_rise_at_centre)
      else $error("recovered clock rose off bit centre");
   property p_data_change;
      @(posedge clk) disable iff (!resetn)
         (st_q == RSC_RUN && $past(st_q) == RSC_RUN && !$past(centre))
         |-> $stable(rx_data_pin);
   endproperty
   a_data_change: assert property (p_data_change)
      else $error("data changed between recovered clock rises");
endmodule
`default_nettype wire

/* File: rsc_host_model.sv */
// Host model: arms recovery, takes 8 bits on clock falls, then disarms
`timescale 1ns/1ps
`default_nettype none
module rsc_host_model (
   input wire logic clk, // Block clock, used to see pin edges
   input wire logic arm, // Bench asks for one packet
   input wire logic rx_data_pin, // Data from block
   input wire logic recovered_clock_pin, // Bit clock from block
   output logic recovery_enable_bit, // Enable to block
   output logic [7:0] pkt_q, // Bits taken, first bit ends in MSB
   output logic [3:0] n_bits_q // Bits taken since arm
);
   logic rclk_q;
   // Power-on value of the enable is zero
   initial begin
      recovery_enable_bit = 1'h0;
      pkt_q = 8'h00;
      n_bits_q = 4'h0;
      rclk_q = 1'h0;
   end
   // Take data on a clock fall, when it has settled since the rise
   always @(posedge clk) begin
      rclk_q <= recovered_clock_pin;
      if (!arm)
         n_bits_q <= 4'h0;
      else if (rclk_q && !recovered_clock_pin && n_bits_q < 4'h8) begin
         pkt_q <= {pkt_q[6:0], rx_data_pin};
         n_bits_q <= n_bits_q + 4'h1;
      end
   end
   // Arm once per request; clear as soon as the packet is complete
   always @(negedge clk) begin
      if (arm && n_bits_q == 4'h0)
         recovery_enable_bit <= 1'h1;
      if (n_bits_q == 4'h8)
         recovery_enable_bit <= 1'h0;
   end
endmodule
`default_nettype wire

/* File: rsc_top_tb_top.sv */
// Testbench for the receive start-symbol and clock recovery block
`timescale 1ns/1ps
`default_nettype none
module rsc_top_tb_top;
   localparam int BC = 16; // 64 ns per line bit
   localparam logic [7:0] PKT = 8'hA5;
   localparam logic [7:0] PKT2 = 8'h3C;
   logic clk, resetn, sat, ts, ps, arm, en;
   logic a1, a2, gain, rxd, rclk;
   logic [7:0] pkt;
   logic [3:0] nb;
   int num_errors = 0;
   int samples_checked = 0;
   rsc_top #(.BIT_CYC(BC)) rsc_top_inst (.clk(clk), .resetn(resetn),
      .saturation_onset_flag(sat), .threshold_slicer(ts),
      .peak_relative_slicer(ps), .recovery_enable_bit(en),
      .first_rf_amp_stage(a1), .second_rf_amp_stage(a2),
      .gain_sel_high_q(gain), .rx_data_pin(rxd),
      .recovered_clock_pin(rclk));
   rsc_host_model rsc_host_model_inst (.clk(clk), .arm(arm),
      .rx_data_pin(rxd), .recovered_clock_pin(rclk),
      .recovery_enable_bit(en), .pkt_q(pkt), .n_bits_q(nb));
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // One line bit on both slicers; chk looks at the pins mid-bit
   task automatic send(input logic b, input logic chk);
      ts = b;
      ps = b;
      cyc(6);
      if (chk) begin
         check(rxd, b);
         check(rclk, 1'h0);
      end
      cyc(BC - 6);
   endtask
   // Two full periods hold a fixed count whatever the start phase
   task automatic t_amp;
      logic [15:0] n1, n2, nboth, nnone;
      n1 = 16'h0000;
      n2 = 16'h0000;
      nboth = 16'h0000;
      nnone = 16'h0000;
      repeat (812) begin
         @(negedge clk);
         n1 += (a1 && !a2);
         n2 += (a2 && !a1);
         nboth += (a1 && a2);
         nnone += (!a1 && !a2);
      end
      check(n1, 16'h0194);
      check(n2, 16'h0194);
      check(nboth, 16'h0000);
      check(nnone, 16'h0004);
      $display("t_amp done");
   endtask
   task automatic t_gain;
      sat = 1'h1;
      cyc(5);
      check(gain, 1'h0);
      sat = 1'h0;
      cyc(5);
      check(gain, 1'h1);
      $display("t_gain done");
   endtask
   task automatic t_raw;
      for (int i = 0; i < 4; i++) begin
         ts = i[1];
         ps = i[0];
         cyc(6);
         check(rxd, i == 3);
         check(rclk, 1'h0);
      end
      $display("t_raw done");
   endtask
   task automatic t_rec;
      logic [15:0] hi;
      hi = 16'h0000;
      arm = 1'h1;
      cyc(8);
      for (int i = 15; i >= 0; i--) send(rsc_pkg::START_PATTERN[i], 1'h1);
      for (int i = 7; i >= 0; i--) send(PKT[i], 1'h0);
      for (int i = 0; i < 400 && nb != 4'h8; i++) cyc(1);
      check(pkt, PKT);
      check(nb, 4'h8);
      // After the clear no further pulse and the pin is raw again (AND low)
      ts = 1'h1;
      ps = 1'h0;
      repeat (4 * BC) begin
         @(negedge clk);
         hi += rclk;
      end
      check(hi, 16'h0000);
      check(rxd, 1'h0);
      // A second pattern without a new enable must not start clocking
      for (int i = 15; i >= 0; i--) send(rsc_pkg::START_PATTERN[i], 1'h1);
      send(1'h1, 1'h1);
      arm = 1'h0;
      $display("t_rec done");
   endtask
   // Enable again after a clear: detection and clocking come back
   task automatic t_rearm;
      cyc(2);
      arm = 1'h1;
      cyc(8);
      for (int i = 15; i >= 0; i--) send(rsc_pkg::START_PATTERN[i], 1'h1);
      for (int i = 7; i >= 0; i--) send(PKT2[i], 1'h0);
      for (int i = 0; i < 400 && nb != 4'h8; i++) cyc(1);
      check(pkt, PKT2);
      check(nb, 4'h8);
      arm = 1'h0;
      $display("t_rearm done");
   endtask
   initial begin
      repeat (6000) @(posedge clk);
      num_errors++;
      report_and_stop;
   end
   initial begin
      resetn = 1'h0;
      sat = 1'h0;
      ts = 1'h0;
      ps = 1'h0;
      arm = 1'h0;
      cyc(2);
      resetn = 1'h1;
      cyc(1);
      check(gain, rsc_pkg::GAIN_SEL_RST);
      t_amp;
      t_gain;
      t_raw;
      t_rec;
      t_rearm;
      report_and_stop;
   end
endmodule
`default_nettype wire
